// [src/uhsf_defines.svh]
// Offsets, field positions, reset values and encodings of the status flags
`ifndef UHSF_DEFINES_SVH
`define UHSF_DEFINES_SVH
`define UHSF_STATUS_OFFSET 8'h02
`define UHSF_STATUS_RESET 16'h0020
`define UHSF_BIT_CMPL 0
`define UHSF_BIT_XERR 1
`define UHSF_BIT_RSM 2
`define UHSF_BIT_SYSERR 3
`define UHSF_BIT_PROCERR 4
`define UHSF_BIT_HALTED 5
`define UHSF_CLEARABLE_MASK 16'h001f
`define UHSF_EN_XERR 0
`define UHSF_EN_RSM 1
`define UHSF_EN_IOC 2
`define UHSF_EN_SHORT 3
`endif

// [src/uhsf_pkg.sv]
// Types shared by the status flag block
package uhsf_pkg;
   // One finished USB transaction, reported by the transfer engine
   typedef struct packed {
      logic done;      // Transaction finished this cycle
      logic err;       // Ended with an error, e.g. error counter underflow
      logic interrupt_on_complete;       // Descriptor asked for interrupt on complete
      logic short_pkt; // Actual length below maximum length
      logic spd_en;    // Descriptor enables short packet detection
   } uhsf_xact_t;
   // I/O register access
   typedef struct packed {
      logic [7:0] addr;  // Byte offset from the I/O base
      logic rd;          // Read strobe, one cycle
      logic wr;          // Write strobe, one cycle
      logic [1:0] be;    // Byte enables, bit 0 is the low byte
      logic [15:0] wdata; // Write data
   } uhsf_io_req_t;
endpackage : uhsf_pkg

// [src/uhsf_status.sv]
// Status register and flag logic of the USB host controller
//
// Overview of operation
// - Write 1 clears a flag, 0 keeps it
// - Halted bit reads 1 after reset, reflects stop
// - Descriptor consistency failure sets process error flag
// - Process error stops schedule and raises interrupt
// - Host access parity or abort sets system error
// - System error stops schedule and raises interrupt
// - Device resume sets resume flag during suspend
// - Transaction error sets the error interrupt flag
// - Error with completion request sets both flags
// - Completion with request sets completion flag
// - Enabled short packet sets completion flag
// - Finish running transaction before reporting halted
// - Flags latch unmasked; fatal errors always interrupt
`timescale 1ns/100ps
`include "uhsf_defines.svh"

module uhsf_status
   import uhsf_pkg::*;
(
   input wire logic clk,                 // Controller clock, 100 MHz
   input wire logic srst,                // Synchronous reset, active high
   input wire uhsf_io_req_t io_req,      // I/O register request
   output logic [15:0] io_rdata,         // Read data, valid cycle after rd
   input wire logic run_bit,             // Schedule run bit of command register
   input wire logic suspend_bit,         // Global suspend bit of command register
   input wire logic [3:0] int_enable,    // Interrupt enable register bits
   input wire logic xact_busy,           // A USB transaction is in progress
   input wire uhsf_xact_t xact,          // Transaction completion report
   input wire logic consistency_fail,    // Fatal descriptor check failure pulse
   input wire logic host_bus_error,      // Parity, master or target abort pulse
   input wire logic resume_seen,         // Resume signalling from a device
   output logic run_clear,               // Pulse: hardware clears run bit
   output logic irq                      // Interrupt to the system
);

   ////////////////////////////////////////////////////////////////////////////
   // Flag state
   logic cmpl_reg;      // Completion interrupt flag
   logic xerr_reg;      // Transaction error flag
   logic rsm_reg;       // Resume detect flag
   logic syserr_reg;    // Host system error flag
   logic procerr_reg;   // Process error flag
   logic halted_reg;    // Controller halted flag
   logic cmpl_src_short_reg; // Last completion came from a short packet
   logic [15:0] status; // Assembled register view
   logic wr_hit;        // Low byte write to the status register
   logic [15:0] clr;    // Write-one-to-clear mask

   // Decode of a status write; only the low byte holds writable bits
   assign wr_hit = io_req.wr && io_req.be[0] && (io_req.addr == `UHSF_STATUS_OFFSET);
   assign clr = wr_hit ? (io_req.wdata & `UHSF_CLEARABLE_MASK) : 16'h0000;

   // Event terms
   logic set_cmpl;    // Completion event
   logic set_xerr;    // Transaction error event
   logic set_rsm;     // Resume event while suspended
   assign set_cmpl = xact.done && (xact.interrupt_on_complete || (xact.short_pkt && xact.spd_en));
   assign set_xerr = xact.done && xact.err;
   assign set_rsm = resume_seen && suspend_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags: a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (srst) begin
         cmpl_reg <= 1'b0;
         xerr_reg <= 1'b0;
         rsm_reg <= 1'b0;
         syserr_reg <= 1'b0;
         procerr_reg <= 1'b0;
      end else begin
         cmpl_reg <= set_cmpl | (cmpl_reg & ~clr[`UHSF_BIT_CMPL]);
         xerr_reg <= set_xerr | (xerr_reg & ~clr[`UHSF_BIT_XERR]);
         rsm_reg <= set_rsm | (rsm_reg & ~clr[`UHSF_BIT_RSM]);
         syserr_reg <= host_bus_error | (syserr_reg & ~clr[`UHSF_BIT_SYSERR]);
         procerr_reg <= consistency_fail | (procerr_reg & ~clr[`UHSF_BIT_PROCERR]);
      end
   end

   // Source of the completion flag, for the matching enable bit
   always_ff @(posedge clk) begin
      if (srst) begin
         cmpl_src_short_reg <= 1'b0;
      end else if (set_cmpl) begin
         cmpl_src_short_reg <= ~xact.interrupt_on_complete;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Halted: set only once the run bit is low or being cleared and no transaction is running
   always_ff @(posedge clk) begin
      if (srst) begin
         halted_reg <= 1'b1;
      end else if (run_bit && !run_clear) begin
         halted_reg <= 1'b0;
      end else if (!xact_busy) begin
         halted_reg <= 1'b1;
      end
   end

   // Fatal errors drop the run bit in the command register
   assign run_clear = consistency_fail | host_bus_error;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: fatal flags unmaskable, the rest gated by enables
   logic cmpl_en; // Enable matching the completion source
   assign cmpl_en = cmpl_src_short_reg ? int_enable[`UHSF_EN_SHORT] : int_enable[`UHSF_EN_IOC];
   assign irq = procerr_reg | syserr_reg
      | (cmpl_reg & cmpl_en)
      | (xerr_reg & int_enable[`UHSF_EN_XERR])
      | (rsm_reg & int_enable[`UHSF_EN_RSM]);

   ////////////////////////////////////////////////////////////////////////////
   // Register view and read port
   assign status = {10'h000, halted_reg, procerr_reg, syserr_reg, rsm_reg, xerr_reg,
      cmpl_reg};

   // Read data registered one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk) begin
      if (srst) begin
         io_rdata <= 16'h0000;
      end else if (io_req.rd && io_req.addr == `UHSF_STATUS_OFFSET) begin
         io_rdata <= status;
      end else begin
         io_rdata <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_clear_write(int b);
      wr_hit && io_req.wdata[b];
   endsequence

   // Fatal error: run bit drop in the same cycle, flag and interrupt next
   sequence s_stop_then_flag(flag);
      run_clear ##1 (flag && irq);
   endsequence

   a_reset_value: assert property (@(posedge clk)
      srst |=> status == `UHSF_STATUS_RESET)
      else $error("status not at reset value after reset");

   a_w1c_clear: assert property (@(posedge clk) disable iff (srst)
      s_clear_write(`UHSF_BIT_XERR) ##0 !set_xerr |=> !xerr_reg)
      else $error("error flag survived a write of one");

   a_w0_keep: assert property (@(posedge clk) disable iff (srst)
      wr_hit && !io_req.wdata[`UHSF_BIT_RSM] && rsm_reg |=> rsm_reg)
      else $error("resume flag lost on write of zero");

   a_procerr_set: assert property (@(posedge clk) disable iff (srst)
      consistency_fail |=> procerr_reg && irq)
      else $error("process error not flagged");

   a_procerr_stop: assert property (@(posedge clk) disable iff (srst)
      consistency_fail |-> s_stop_then_flag(procerr_reg))
      else $error("process error did not stop schedule");

   a_syserr_stop: assert property (@(posedge clk) disable iff (srst)
      host_bus_error |-> s_stop_then_flag(syserr_reg))
      else $error("system error not flagged or not stopped");

   a_syserr_irq: assert property (@(posedge clk) disable iff (srst)
      syserr_reg |-> irq)
      else $error("system error without interrupt");

   a_resume_set: assert property (@(posedge clk) disable iff (srst)
      resume_seen && suspend_bit |=> rsm_reg)
      else $error("resume not flagged during suspend");

   a_xerr_set: assert property (@(posedge clk) disable iff (srst)
      xact.done && xact.err |=> xerr_reg)
      else $error("transaction error not flagged");

   a_both_flags: assert property (@(posedge clk) disable iff (srst)
      xact.done && xact.err && xact.interrupt_on_complete |=> xerr_reg && cmpl_reg)
      else $error("error with completion request missed a flag");

   a_ioc_set: assert property (@(posedge clk) disable iff (srst)
      xact.done && xact.interrupt_on_complete |=> cmpl_reg)
      else $error("completion flag not set");

   a_short_set: assert property (@(posedge clk) disable iff (srst)
      xact.done && xact.short_pkt && xact.spd_en |=> cmpl_reg)
      else $error("short packet not flagged");

   a_halt_waits: assert property (@(posedge clk) disable iff (srst)
      !run_bit && xact_busy && !halted_reg |=> !halted_reg)
      else $error("halted before transaction finished");

   a_halt_rises: assert property (@(posedge clk) disable iff (srst)
      !run_bit && !xact_busy |=> halted_reg)
      else $error("halted not reported when stopped");

   a_poll_masked: assert property (@(posedge clk) disable iff (srst)
      int_enable == 4'h0 && set_xerr |=> xerr_reg)
      else $error("masked event did not latch");

   a_rsvd_zero: assert property (@(posedge clk)
      status[15:6] == 10'h000)
      else $error("reserved bits not zero");

   a_halt_drops: assert property (@(posedge clk) disable iff (srst)
      run_bit && !run_clear |=> !halted_reg)
      else $error("halted still set while running");

   a_resume_ignored: assert property (@(posedge clk) disable iff (srst)
      !suspend_bit && !rsm_reg |=> !rsm_reg)
      else $error("resume flagged outside suspend");

   a_no_spurious_cmpl: assert property (@(posedge clk) disable iff (srst)
      xact.done && !xact.interrupt_on_complete && !(xact.short_pkt && xact.spd_en) && !cmpl_reg |=> !cmpl_reg)
      else $error("completion flag set without a cause");

   a_byte_guard: assert property (@(posedge clk) disable iff (srst)
      io_req.wr && !io_req.be[0] && rsm_reg |=> rsm_reg)
      else $error("flag cleared by a high byte write");

   a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
      !(io_req.rd && io_req.addr == `UHSF_STATUS_OFFSET) |=> io_rdata == 16'h0000)
      else $error("read data not zero outside a status read");

   a_rdata_value: assert property (@(posedge clk) disable iff (srst)
      io_req.rd && io_req.addr == `UHSF_STATUS_OFFSET |=> io_rdata == $past(status))
      else $error("read data differs from status");

endmodule : uhsf_status

// [dv/test_uhsf_status.sv]
// Self-checking bench of the status flag block
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end

module test_uhsf_status import uhsf_pkg::*;;
   logic clk = 1'b0; // 100 MHz clock
   logic srst = 1'b1; // Synchronous reset
   uhsf_io_req_t io_req = '0; // Register request
   logic [15:0] io_rdata; // Read data
   logic run_bit = 1'b0, suspend_bit = 1'b0, xact_busy = 1'b0;
   logic consistency_fail = 1'b0, host_bus_error = 1'b0, resume_seen = 1'b0;
   logic [3:0] int_enable = 4'h0; // Interrupt enables
   uhsf_xact_t xact = '0; // Completion report
   logic run_clear, irq; // Outputs under test
   int fails = 0, samples_checked = 0;
   logic [15:0] v; // Last read value
   logic rc; // Captured run clear

   always #5 clk = ~clk;

   uhsf_status i_uhsf_status (.clk(clk), .srst(srst), .io_req(io_req), .io_rdata(io_rdata),
      .run_bit(run_bit), .suspend_bit(suspend_bit), .int_enable(int_enable),
      .xact_busy(xact_busy), .xact(xact), .consistency_fail(consistency_fail),
      .host_bus_error(host_bus_error), .resume_seen(resume_seen), .run_clear(run_clear),
      .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   // Register access and event helpers
   task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
      @(posedge clk) io_req <= '{a, 1'b0, 1'b1, b, d};
      @(posedge clk) io_req <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk) io_req <= '{a, 1'b1, 1'b0, 2'h0, 16'h0000};
      @(posedge clk) io_req <= '0;
      #1 d = io_rdata;
   endtask : rd

   // One-cycle event pulse; run_clear sampled in the pulse cycle
   task automatic fire(input logic cf, hb, rs, input uhsf_xact_t x, output logic c);
      @(posedge clk) begin
         consistency_fail <= cf;
         host_bus_error <= hb;
         resume_seen <= rs;
         xact <= x;
      end
      #1 c = run_clear;
      @(posedge clk) {consistency_fail, host_bus_error, resume_seen, xact} <= 8'h00;
      #1;
   endtask : fire

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_halt();
      @(posedge clk) {run_bit, xact_busy} <= 2'b11;
      rd(8'h02, v);
      `CHK(v, 16'h0000)
      @(posedge clk) run_bit <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h02, v);
      `CHK(v, 16'h0000)
      @(posedge clk) xact_busy <= 1'b0;
      rd(8'h02, v);
      `CHK(v, 16'h0020)
   endtask : t_halt

   // Fatal error: sel 0 process error, sel 1 host system error
   task automatic t_fatal(input logic sel);
      logic [15:0] e;
      e = sel ? 16'h0008 : 16'h0010;
      @(posedge clk) run_bit <= 1'b1;
      fire(!sel, sel, 1'b0, '0, rc);
      `CHK(rc, 1'b1)
      `CHK(irq, 1'b1)
      @(posedge clk) run_bit <= 1'b0;
      rd(8'h02, v);
      `CHK(v, 16'h0020 | e)
      wr(8'h02, 2'h1, ~e & 16'h001f);
      rd(8'h02, v);
      `CHK(v, 16'h0020 | e)
      wr(8'h02, 2'h1, e);
      rd(8'h02, v);
      `CHK(v, 16'h0020)
      `CHK(irq, 1'b0)
   endtask : t_fatal

   task automatic t_xact();
      logic [3:0] c[5] = '{4'b1100, 4'b1000, 4'b0100, 4'b0011, 4'b0010};
      logic [1:0] e[5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b00};
      @(posedge clk) run_bit <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         @(posedge clk) int_enable <= m ? 4'hf : 4'h0;
         for (int k = 0; k < 5; k++) begin
            fire(1'b0, 1'b0, 1'b0, {1'b1, c[k]}, rc);
            `CHK(irq, (m == 1) && (e[k] != 2'b00))
            rd(8'h02, v);
            `CHK(v, 16'(e[k]))
            wr(8'h02, 2'h1, 16'h0003);
         end
      end
   endtask : t_xact

   // The completion and error enables each gate only their own source; the short packet enable is checked on its own source only
   task automatic t_enable();
      logic [3:0] en[5] = '{4'h4, 4'h4, 4'h8, 4'h1, 4'h1};
      logic [3:0] c[5] = '{4'b0011, 4'b0100, 4'b0011, 4'b1000, 4'b0100};
      logic q[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int k = 0; k < 5; k++) begin
         @(posedge clk) int_enable <= en[k];
         fire(1'b0, 1'b0, 1'b0, {1'b1, c[k]}, rc);
         `CHK(irq, q[k])
         wr(8'h02, 2'h1, 16'h0003);
      end
   endtask : t_enable

   task automatic t_resume();
      fire(1'b0, 1'b0, 1'b1, '0, rc);
      rd(8'h02, v);
      `CHK(v, 16'h0000)
      @(posedge clk) suspend_bit <= 1'b1;
      fire(1'b0, 1'b0, 1'b1, '0, rc);
      rd(8'h02, v);
      `CHK(v, 16'h0004)
      wr(8'h02, 2'h1, 16'h001b);
      rd(8'h02, v);
      `CHK(v, 16'h0004)
      wr(8'h02, 2'h2, 16'hffff);
      rd(8'h02, v);
      `CHK(v, 16'h0004)
      wr(8'h02, 2'h3, 16'hffe4);
      rd(8'h02, v);
      `CHK(v, 16'h0000)
      @(posedge clk) suspend_bit <= 1'b0;
      rd(8'h04, v);
      `CHK(v, 16'h0000)
   endtask : t_resume

   // Reset with flags pending drops every flag and reports halted again
   task automatic t_reset();
      @(posedge clk) run_bit <= 1'b0;
      fire(1'b1, 1'b0, 1'b0, {1'b1, 4'b1100}, rc);
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      `CHK(irq, 1'b0)
      rd(8'h02, v);
      `CHK(v, 16'h0020)
   endtask : t_reset

   task automatic close_out();
      if (fails == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rd(8'h02, v);
      `CHK(v, 16'h0020)
      t_halt();
      t_fatal(1'b0);
      t_fatal(1'b1);
      t_xact();
      t_enable();
      t_resume();
      t_reset();
      close_out();
   end
endmodule : test_uhsf_status
